// *** hw/cts_map.svh ***
// cycle timing sequencer: offsets, field positions, reset values, tap positions and timing counts
// assumes a 100 MHz system clock; included by the package and the top module
`ifndef CTS_MAP_SVH
`define CTS_MAP_SVH

`define CTS_CLK_PERIOD_NS 10
`define CTS_SHIFT_PERIOD_NS 50
`define CTS_TICK_CLKS ((`CTS_SHIFT_PERIOD_NS + `CTS_CLK_PERIOD_NS - 1) / `CTS_CLK_PERIOD_NS)
`define CTS_TICK_W 3
`define CTS_STAGES 28
// the 100 ns low pulse starts in stages 0 and 1
`define CTS_CHAIN_INIT 28'hFFFFFFC

`define CTS_FAST_SAVE_NS 200
`define CTS_FAST_SKIP (`CTS_FAST_SAVE_NS / `CTS_SHIFT_PERIOD_NS)
`define CTS_TAP_FAST 6

`define CTS_TAP_TS1_ON 0
`define CTS_TAP_TS2_ON 4
`define CTS_TAP_TS3_ON 13
`define CTS_TAP_TS4_ON 18
`define CTS_TAP_TP1 3
`define CTS_TAP_TP2 12
`define CTS_TAP_TP3 17
`define CTS_TAP_TP4 27

`define CTS_WH_LO 12
`define CTS_STALL_LO 16
`define CTS_STALL_HI 19

`define CTS_RET_LAG_NS 50
`define CTS_RET_LAG (`CTS_RET_LAG_NS / `CTS_SHIFT_PERIOD_NS)
`define CTS_INH_LAG_NS 100
`define CTS_INH_LAG (`CTS_INH_LAG_NS / `CTS_SHIFT_PERIOD_NS)
`define CTS_TAP_RD_ON 1
`define CTS_TAP_STRB_ON 3
`define CTS_TAP_STRB_OFF 5
`define CTS_TAP_RD_SRC_OFF 5
`define CTS_TAP_RD_RET_OFF (`CTS_TAP_RD_SRC_OFF + `CTS_RET_LAG)
`define CTS_TAP_WR_ON 12
`define CTS_TAP_INH_ON (`CTS_TAP_WR_ON + `CTS_INH_LAG)
`define CTS_TAP_WR_SRC_OFF 15
`define CTS_TAP_WR_RET_OFF (`CTS_TAP_WR_SRC_OFF + `CTS_RET_LAG)
`define CTS_TAP_WR_OFF 16

`define CTS_REG_CTRL 8'h00
`define CTS_REG_STATUS 8'h04
`define CTS_REG_CYCLES 8'h08
`define CTS_CTRL_SLOW_ONLY 0
`define CTS_CTRL_RESET 1'h0
`define CTS_ST_FAST 4
`define CTS_ST_IO_CONT 5
`define CTS_ST_SHIFT_HOLD 6
`define CTS_ST_CLAMP 7

`endif

// *** hw/cts_pkg.sv ***
// cycle timing sequencer: state types
// assumes cts_map.svh is on the include path
package cts_pkg;
`include "cts_map.svh"

   typedef struct packed {
      logic [`CTS_STAGES-1:0] chain;
      logic [`CTS_TICK_W-1:0] tick_cnt;
      logic ts1;
      logic ts2;
      logic ts3;
      logic ts4;
      logic [3:0] tp;
      logic src;
      logic ret;
      logic strb;
      logic wr;
      logic inh;
      logic io_cont;
      logic shift_hold;
      logic fast;
      logic slow_only;
      logic strobe_prev;
      logic [15:0] cycles;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cts_state_s;

endpackage

// *** hw/cts_sync.sv ***
// cycle timing sequencer: two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module cts_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } cts_sync_s;

   cts_sync_s s;
   cts_sync_s next_s;

   always_comb begin
      next_s.meta = d;
      next_s.sync = s.meta;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= {RESET_VAL, RESET_VAL};
      end else begin
         s <= next_s;
      end
   end

   assign q = s.sync;
endmodule // cts_sync
`default_nettype wire

// *** hw/cts_top.sv ***
// cycle timing sequencer: shift chain, time states, pulses, memory drive timing, i/o stall, apb registers
// assumes a 100 MHz clk, pins asynchronous, fast_state_entered from processor logic on clk
// Functional notes
// [RL1] time states follow in order; each pulse brackets its state's trailing edge
// [RL2] only time_state_2 differs between cycles; fast cycle is 200 ns shorter
// [RL3] slow cycle for read-modify-write, fast cycle for fetch-style rewrite
// [RL4] four set/reset latches for states, four tap decodes for pulses
// [RL5] clamp forces time_state_1 set and other time states clear
// [RL6] memory signals come from tap-driven latches held reset under clamp
// [RL7] return and source rise together; return falls 50 ns after source
// [RL8] sense strobe only in the read half
// [RL9] write and inhibit only in write half; inhibit 100 ns after write
// [RL10] pending low from peripheral stalls the cycle in time_state_3 at pulse 3
// [RL11] peripheral strobes each transfer, negates pending before the last
// [RL12] stall stage low with io_continue_flag set ends state 3, starts 4
// [RL13] pending asserted clears io_continue_flag at timing pulse 3
// [RL14] clock after clear drops shift_hold_flag; pulse frozen in stall stage
// [RL15] write half stage keeps shifting during a stall
// [RL16] final strobe sets continue flag; next clock restores shifting
// [RL17] i/o stalls arise only within fast cycles; with slow_only set the stall logic runs in slow cycles too
// [RL18] one stage per 50 ns; 28 stages give a 1.4 us slow cycle
// [RL19] normal operation uses a 1.2 us fast cycle
// [RL20] fast cycle selected on entry to fetch or non-autoindexed indirect state
// [RL21] taps chosen on the 50 ns grid to meet the durations
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cts_map.svh"
module cts_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_clamp_n,
   input wire logic more_transfers_pending_n,
   input wire logic transfer_strobe_n,
   input wire logic fast_state_entered,
   output logic time_state_1,
   output logic time_state_2,
   output logic time_state_3,
   output logic time_state_4,
   output logic timing_pulse_1,
   output logic timing_pulse_2,
   output logic timing_pulse_3,
   output logic timing_pulse_4,
   output logic source_current,
   output logic return_current,
   output logic sense_strobe,
   output logic write_current,
   output logic inhibit_current
);
   localparam logic [`CTS_TICK_W-1:0] TICK_LAST = `CTS_TICK_W'(`CTS_TICK_CLKS - 1);

   cts_pkg::cts_state_s s;
   cts_pkg::cts_state_s next_s;
   logic [2:0] pins_s;
   logic clamp_n_s;
   logic pending_n_s;
   logic strobe_n_s;
   logic tick;
   logic strobe_fall;
   logic apb_access;
   logic [31:0] rd_word;
   logic rd_err;

   cts_sync #(.W(3), .RESET_VAL(3'h7)) u_sync (
      .clk(clk),
      .reset(reset),
      .d({power_clamp_n, more_transfers_pending_n, transfer_strobe_n}),
      .q(pins_s)
   );
   assign clamp_n_s = pins_s[2];
   assign pending_n_s = pins_s[1];
   assign strobe_n_s = pins_s[0];

   // one shift step; fast bypass and stall freeze applied on top of the plain rotate
   function automatic logic [`CTS_STAGES-1:0] chain_step(input logic [`CTS_STAGES-1:0] c, input logic fast,
                                                        input logic hold);
      logic [`CTS_STAGES-1:0] n;
      n = {c[`CTS_STAGES-2:0], c[`CTS_STAGES-1]}; // RL18
      if (fast) begin
         n[`CTS_TAP_FAST+1] = 1'b1; // RL2
         n[`CTS_TAP_FAST+`CTS_FAST_SKIP+1] = c[`CTS_TAP_FAST]; // RL2
      end
      if (!hold) begin
         n[`CTS_STALL_HI:`CTS_STALL_LO] = c[`CTS_STALL_HI:`CTS_STALL_LO]; // RL14
         n[`CTS_STALL_HI+1] = 1'b1; // RL14
      end
      return n;
   endfunction

   function automatic logic [31:0] reg_read(input logic [7:0] a, input cts_pkg::cts_state_s st,
                                            input logic clamp_n);
      logic [31:0] w;
      w = 32'h0;
      unique case (a)
         `CTS_REG_CTRL: w[`CTS_CTRL_SLOW_ONLY] = st.slow_only;
         `CTS_REG_STATUS: begin
            w[3:0] = {st.ts4, st.ts3, st.ts2, st.ts1};
            w[`CTS_ST_FAST] = st.fast;
            w[`CTS_ST_IO_CONT] = st.io_cont;
            w[`CTS_ST_SHIFT_HOLD] = st.shift_hold;
            w[`CTS_ST_CLAMP] = ~clamp_n;
         end
         `CTS_REG_CYCLES: w[15:0] = st.cycles;
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   always_comb begin
      next_s = s;
      tick = (s.tick_cnt == TICK_LAST);
      strobe_fall = s.strobe_prev & ~strobe_n_s;
      next_s.strobe_prev = strobe_n_s;
      next_s.tick_cnt = tick ? `CTS_TICK_W'(0) : s.tick_cnt + `CTS_TICK_W'(1);
      if (tick) begin
         next_s.chain = chain_step(s.chain, s.fast, s.shift_hold); // RL15
         next_s.shift_hold = s.io_cont; // RL14 RL16
         if (!s.chain[`CTS_TAP_TP3] && !pending_n_s) begin
            next_s.io_cont = 1'b0; // RL10 RL13
         end
         // speed is latched on the two ticks per cycle while the pulse sits at the chain head
         // i/o stalls only come in fetch cycles, so they run on a fast cycle unless slow_only is set
         if (!s.chain[`CTS_TAP_TS1_ON]) begin
            next_s.fast = fast_state_entered & ~s.slow_only; // RL3 RL17 RL19 RL20
         end
      end
      // final strobe wins over a clear in the same cycle
      if (strobe_fall && pending_n_s) begin
         next_s.io_cont = 1'b1; // RL16
      end
      // time state latches, set/reset by chain taps
      if (!s.chain[`CTS_TAP_TS1_ON]) begin
         next_s.ts4 = 1'b0; // RL1 RL4
         next_s.ts1 = 1'b1;
      end
      if (!s.chain[`CTS_TAP_TS2_ON]) begin
         next_s.ts1 = 1'b0; // RL1 RL4
         next_s.ts2 = 1'b1;
      end
      if (!s.chain[`CTS_TAP_TS3_ON]) begin
         next_s.ts2 = 1'b0; // RL1 RL4
         next_s.ts3 = 1'b1;
      end
      if (!s.chain[`CTS_TAP_TS4_ON] && s.io_cont) begin
         next_s.ts3 = 1'b0; // RL12
         next_s.ts4 = 1'b1;
      end
      next_s.tp = ~{s.chain[`CTS_TAP_TP4], s.chain[`CTS_TAP_TP3], s.chain[`CTS_TAP_TP2],
                    s.chain[`CTS_TAP_TP1]}; // RL4 RL21
      // memory drive latches
      if (!s.chain[`CTS_TAP_RD_ON] || !s.chain[`CTS_TAP_WR_ON]) begin
         next_s.src = 1'b1; // RL7
         next_s.ret = 1'b1;
      end
      if (!s.chain[`CTS_TAP_RD_SRC_OFF] || !s.chain[`CTS_TAP_WR_SRC_OFF]) begin
         next_s.src = 1'b0; // RL7
      end
      if (!s.chain[`CTS_TAP_RD_RET_OFF] || !s.chain[`CTS_TAP_WR_RET_OFF]) begin
         next_s.ret = 1'b0; // RL7
      end
      if (!s.chain[`CTS_TAP_STRB_ON]) begin
         next_s.strb = 1'b1; // RL8
      end
      if (!s.chain[`CTS_TAP_STRB_OFF]) begin
         next_s.strb = 1'b0;
      end
      if (!s.chain[`CTS_TAP_WR_ON]) begin
         next_s.wr = 1'b1; // RL9
      end
      if (!s.chain[`CTS_TAP_INH_ON]) begin
         next_s.inh = 1'b1; // RL9
      end
      if (!s.chain[`CTS_TAP_WR_OFF]) begin
         next_s.wr = 1'b0;
         next_s.inh = 1'b0;
      end
      if (!s.ts1 && next_s.ts1) begin
         next_s.cycles = s.cycles + 16'h1;
      end
      // clamp presets the chain and holds every timing latch
      if (!clamp_n_s) begin
         next_s.chain = `CTS_CHAIN_INIT;
         next_s.tick_cnt = `CTS_TICK_W'(0);
         next_s.ts1 = 1'b1; // RL5
         next_s.ts2 = 1'b0;
         next_s.ts3 = 1'b0;
         next_s.ts4 = 1'b0;
         next_s.tp = 4'h0;
         next_s.src = 1'b0; // RL6
         next_s.ret = 1'b0;
         next_s.strb = 1'b0;
         next_s.wr = 1'b0;
         next_s.inh = 1'b0;
         next_s.io_cont = 1'b1;
         next_s.shift_hold = 1'b1;
      end
      // apb slave: one wait state, then pready with registered data
      apb_access = psel & penable;
      rd_word = reg_read(paddr, s, clamp_n_s);
      rd_err = (paddr != `CTS_REG_CTRL) && (paddr != `CTS_REG_STATUS) && (paddr != `CTS_REG_CYCLES);
      next_s.pready = apb_access & ~s.pready;
      next_s.pslverr = apb_access & ~s.pready & rd_err;
      next_s.prdata = (apb_access && !s.pready && !pwrite) ? rd_word : 32'h0;
      if (apb_access && s.pready && pwrite && paddr == `CTS_REG_CTRL) begin
         next_s.slow_only = pwdata[`CTS_CTRL_SLOW_ONLY];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.chain <= `CTS_CHAIN_INIT;
         s.ts1 <= 1'b1;
         s.io_cont <= 1'b1;
         s.shift_hold <= 1'b1;
         s.slow_only <= `CTS_CTRL_RESET;
         s.strobe_prev <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign time_state_1 = s.ts1;
   assign time_state_2 = s.ts2;
   assign time_state_3 = s.ts3;
   assign time_state_4 = s.ts4;
   assign timing_pulse_1 = s.tp[0];
   assign timing_pulse_2 = s.tp[1];
   assign timing_pulse_3 = s.tp[2];
   assign timing_pulse_4 = s.tp[3];
   assign source_current = s.src;
   assign return_current = s.ret;
   assign sense_strobe = s.strb;
   assign write_current = s.wr;
   assign inhibit_current = s.inh;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !clamp_n_s);

   // time states and pulses
   ts_onehot_a: assert property ($onehot({s.ts4, s.ts3, s.ts2, s.ts1})) // RL1
      else $error("time states not one-hot");
   pulse_width_a: assert property ($rose(s.tp[0]) |-> s.tp[0][*8] ##1 s.tp[0] ##1 s.tp[0] ##1 !s.tp[0]) // RL4
      else $error("timing pulse not 100 ns wide");
   fast_ts2_a: assert property ($rose(s.ts2) && s.fast |-> ##24 s.ts2 ##1 !s.ts2) // RL2
      else $error("fast time_state_2 length wrong");
   slow_ts2_a: assert property ($rose(s.ts2) && !s.fast |-> ##44 s.ts2 ##1 !s.ts2) // RL2
      else $error("slow time_state_2 length wrong");
   // clamp and memory drive
   clamp_ts_a: assert property (disable iff (reset) !clamp_n_s |=> s.ts1 && !s.ts2 && !s.ts3 && !s.ts4) // RL5
      else $error("clamp did not force time_state_1");
   clamp_mem_a: assert property (disable iff (reset) !clamp_n_s |=> !(s.src | s.ret | s.strb | s.wr | s.inh)) // RL6
      else $error("clamp did not reset memory latches");
   src_ret_rise_a: assert property ($rose(s.src) |-> $rose(s.ret)) // RL7
      else $error("source and return did not rise together");
   ret_lag_a: assert property ($fell(s.src) |-> s.ret[*5] ##1 !s.ret) // RL7
      else $error("return did not fall 50 ns after source");
   strobe_read_a: assert property (s.strb |-> !s.wr && !s.inh) // RL8
      else $error("sense strobe outside read half");
   inhibit_lag_a: assert property ($rose(s.wr) |-> !s.inh ##9 !s.inh ##1 s.inh) // RL9
      else $error("inhibit not 100 ns after write");
   // i/o stall
   io_clear_a: assert property (tick && !s.chain[`CTS_TAP_TP3] && !pending_n_s && !(strobe_fall && pending_n_s)
                                |=> !s.io_cont) // RL13
      else $error("continue flag not cleared at pulse 3");
   hold_follow_a: assert property (tick && !s.io_cont |=> !s.shift_hold) // RL14
      else $error("shift hold did not follow continue flag");
   stall_freeze_a: assert property (tick && !s.shift_hold |=> $stable(s.chain[`CTS_STALL_HI:`CTS_STALL_LO])) // RL14
      else $error("stall stage moved during hold");
   wr_shift_a: assert property (tick && !s.shift_hold |=>
      s.chain[`CTS_WH_LO+3:`CTS_WH_LO] == $past(s.chain[`CTS_WH_LO+2:`CTS_WH_LO-1])) // RL15
      else $error("write half stopped shifting during hold");
   ts3_stay_a: assert property (s.ts3 && !s.io_cont |=> s.ts3 && !s.ts4) // RL10
      else $error("time_state_3 left while stalled");
   resume_a: assert property (s.ts3 && s.io_cont && !s.chain[`CTS_TAP_TS4_ON] |=> s.ts4) // RL12 RL16
      else $error("time_state_4 not entered");


   // cover the main scenarios
   fast_cycle_c: cover property (s.fast && $rose(s.ts3));
   slow_cycle_c: cover property (!s.fast && $rose(s.ts3));
   io_stall_c: cover property (!s.shift_hold ##[1:200] s.shift_hold);
   apb_write_c: cover property (psel && penable && pready && pwrite);
   clamp_release_c: cover property ($rose(clamp_n_s));
endmodule // cts_top
`default_nettype wire

// *** bench/cts_periph.sv ***
// peripheral model: stalls one io instruction and strobes each transfer
// assumes pull-ups keep both lines high while idle
`timescale 1ns/1ps
`default_nettype none
module cts_periph (
   input wire logic clk,
   input wire logic go,
   input wire logic [2:0] n_xfer,
   input wire logic [3:0] gap,
   input wire logic time_state_2,
   input wire logic time_state_3,
   output logic more_transfers_pending_n,
   output logic transfer_strobe_n
);
   initial begin
      more_transfers_pending_n = 1'b1;
      transfer_strobe_n = 1'b1;
      forever begin
         @(posedge clk);
         if (go && time_state_2) begin
            more_transfers_pending_n <= 1'b0;
            while (!time_state_3) @(posedge clk);
            repeat (60) @(posedge clk);
            for (int i = 1; i <= n_xfer; i++) begin
               if (i == n_xfer) begin
                  more_transfers_pending_n <= 1'b1;
                  repeat (4) @(posedge clk);
               end
               transfer_strobe_n <= 1'b0;
               repeat (3) @(posedge clk);
               transfer_strobe_n <= 1'b1;
               repeat (5 + gap) @(posedge clk);
            end
            while (go) @(posedge clk);
         end
      end
   end
endmodule // cts_periph
`default_nettype wire

// *** bench/cycle_timing_sequencer_tb.sv ***
// bench: apb master, cycle monitor against a tap model, io stalls, clamp
// assumes cts_top and cts_periph compiled first, cts_map.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "cts_map.svh"
module cycle_timing_sequencer_tb;
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, c0;
   logic pready, pslverr, e, go = 1'b0;
   logic power_clamp_n = 1'b1, fast_state_entered = 1'b0;
   logic more_transfers_pending_n, transfer_strobe_n;
   logic time_state_1, time_state_2, time_state_3, time_state_4;
   logic timing_pulse_1, timing_pulse_2, timing_pulse_3, timing_pulse_4;
   logic source_current, return_current, sense_strobe, write_current, inhibit_current;
   logic [2:0] n_xfer = 3'h1;
   logic [3:0] gap = 4'h0, ts, tp, ts_q = 4'h1;
   logic [4:0] mem, mem_q = 5'h00;
   int fails = 0, total_checks = 0, per = 0, src_off = 0, wr_on = 0, tsc[4] = '{0, 0, 0, 0};
   bit mon_on = 0, mem_on = 0, exp_fast = 0;
   assign ts = {time_state_4, time_state_3, time_state_2, time_state_1};
   assign tp = {timing_pulse_4, timing_pulse_3, timing_pulse_2, timing_pulse_1};
   assign mem = {source_current, return_current, sense_strobe, write_current, inhibit_current};
   always #5 clk = ~clk;
   cts_top uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .power_clamp_n, .more_transfers_pending_n, .transfer_strobe_n, .fast_state_entered,
      .time_state_1, .time_state_2, .time_state_3, .time_state_4, .timing_pulse_1, .timing_pulse_2,
      .timing_pulse_3, .timing_pulse_4, .source_current, .return_current, .sense_strobe,
      .write_current, .inhibit_current);
   cts_periph peer (.clk, .go, .n_xfer, .gap, .time_state_2, .time_state_3,
      .more_transfers_pending_n, .transfer_strobe_n);
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic lim(input bit over);
      if (over) begin
         fails++;
         tally_and_finish;
      end
   endtask
   // state lengths in clocks: tap distance times 50 ns, fast cycle drops 200 ns of state 2
   function automatic int exp_len(input int i);
      int t[4];
      t = '{`CTS_TAP_TS2_ON - `CTS_TAP_TS1_ON, `CTS_TAP_TS3_ON - `CTS_TAP_TS2_ON,
         `CTS_TAP_TS4_ON - `CTS_TAP_TS3_ON, `CTS_STAGES - `CTS_TAP_TS4_ON};
      if (exp_fast) t[1] -= 200 / 50;
      return t[i] * 5;
   endfunction
   always @(posedge clk) begin
      per++;
      src_off++;
      wr_on++;
      for (int i = 0; i < 4; i++) begin
         if (mon_on && ts_q[i] && !ts[i]) begin
            chk(tsc[i], exp_len(i));
            chk(tp[i], 1);
         end
         if (mon_on && !ts_q[i] && ts[i]) chk(ts_q[(i + 3) % 4], 1);
         tsc[i] = ts[i] ? tsc[i] + 1 : 0;
      end
      if (!ts_q[0] && ts[0]) begin
         if (mon_on) chk(per, exp_fast ? 120 : 140);
         per = 0;
      end
      if (mem_on) begin
         if (!mem_q[4] && mem[4]) chk(mem[3], 1);
         if (mem_q[4] && !mem[4]) src_off = 0;
         if (mem_q[3] && !mem[3]) chk(src_off, 5);
         if (!mem_q[2] && mem[2]) chk({mem[4], mem[1:0]}, 3'h4);
         if (!mem_q[1] && mem[1]) wr_on = 0;
         if (!mem_q[0] && mem[0]) chk(wr_on, 10);
      end
      ts_q = ts;
      mem_q = mem;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      lim(n >= 20);
   endtask
   task automatic wait_ts1(input int k);
      int n;
      logic p;
      n = 0;
      p = time_state_1;
      while (k > 0 && n < 2000) begin
         @(posedge clk);
         n++;
         if (!p && time_state_1) k--;
         p = time_state_1;
      end
      lim(k > 0);
   endtask
   task automatic stall_once;
      int n;
      logic s;
      n_xfer <= 3'(1 + $urandom % 4);
      gap <= 4'($urandom % 8);
      mon_on = 0;
      wait_ts1(1);
      go <= 1'b1;
      n = 0;
      while (!time_state_3 && n < 200) begin
         @(posedge clk);
         n++;
      end
      lim(n >= 200);
      repeat (40) @(posedge clk);
      apb(0, `CTS_REG_STATUS, 0);
      chk(r & 32'h7F, 32'h14);
      s = 1'b1;
      n = 0;
      do begin
         s = transfer_strobe_n;
         @(posedge clk);
         n++;
      end while (!(s && !transfer_strobe_n && more_transfers_pending_n) && n < 3000);
      lim(n >= 3000);
      chk(ts, 4'h4);
      n = 0;
      while (!time_state_4 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(n >= 3 && n <= 5, 1);
      go <= 1'b0;
      wait_ts1(2);
      mon_on = 1;
   endtask
   initial begin
      logic [31:0] d;
      void'($urandom(32'h1218358a));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(ts, 4'h1);
      mem_on = 1;
      apb(0, `CTS_REG_CTRL, 0);
      chk(r, 0);
      apb(1, 8'h0C, $urandom);
      chk({e, r}, {1'b1, 32'h0});
      for (int m = 0; m < 3; m++) begin
         d = $urandom;
         d[0] = (m == 0);
         fast_state_entered <= (m != 1);
         apb(1, `CTS_REG_CTRL, d);
         apb(0, `CTS_REG_CTRL, 0);
         chk(r, d & 32'h1);
         mon_on = 0;
         exp_fast = (m == 2);
         wait_ts1(2);
         mon_on = 1;
         apb(0, `CTS_REG_CYCLES, 0);
         c0 = r;
         wait_ts1(2);
         apb(0, `CTS_REG_CYCLES, 0);
         chk(16'(r - c0), 2);
      end
      for (int k = 0; k < 2; k++) stall_once();
      mon_on = 0;
      mem_on = 0;
      power_clamp_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk({tp, mem, ts}, 13'h001);
      apb(0, `CTS_REG_STATUS, 0);
      chk(r & 32'h8F, 32'h81);
      power_clamp_n <= 1'b1;
      wait_ts1(1);
      mem_on = 1;
      wait_ts1(1);
      mon_on = 1;
      wait_ts1(2);
      tally_and_finish;
   end
   initial begin
      repeat (100000) @(posedge clk);
      lim(1'b1);
   end
endmodule // cycle_timing_sequencer_tb
`default_nettype wire
